// [serial_peer.sv]
// Purpose: remote receiver that decodes frames on the transmit line
// Assumes: per clock cycles per bit, per even
// Notes: samples mid-bit; frame is {stop ok, parity, data}
`timescale 1ns/1ps
module serial_peer (
   // clock
   input wire logic clk,
   // line and format
   input wire logic txd,
   input wire logic [3:0] nbits,
   input wire logic par_en,
   input wire logic stop2,
   input wire logic [4:0] per,
   output logic rxd,
   // decoded frame
   output logic [10:0] frame,
   output logic frame_vld
);
   initial begin
      rxd = 1'b1;
      frame_vld = 1'b0;
      frame = 11'h000;
      forever begin
         @(negedge txd);
         repeat (per / 2) @(posedge clk);
         frame = 11'h000;
         for (int i = 0; i < nbits; i++) begin
            repeat (per) @(posedge clk);
            frame[i] = txd;
         end
         if (par_en) begin
            repeat (per) @(posedge clk);
            frame[9] = txd;
         end
         repeat (per) @(posedge clk);
         frame[10] = txd;
         if (stop2) begin
            repeat (per) @(posedge clk);
            frame[10] = frame[10] & txd;
         end
         frame_vld = 1'b1;
         @(posedge clk);
         frame_vld = 1'b0;
      end
   end
endmodule

// [uart_frame_receiver.sv]
// Purpose: asynchronous frame receiver using the shared frame format
// Assumes: rxd already passed a two-flop synchroniser
// Notes: oversamples at the baud generator rate, samples mid-bit
`timescale 1ns/1ps
module uart_frame_receiver
   import uart_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // line and pacing
   input wire logic rxd,
   input wire logic baud_tick,
   // shared configuration
   input wire logic enable,
   input wire logic double_speed,
   input wire logic [2:0] char_size_field,
   input wire logic [1:0] parity_mode_field,
   // results
   output logic [8:0] data_out,
   output logic done,
   output logic frame_err,
   output logic parity_err
);
   import uart_pkg::*;

   rx_state_t state_reg;
   logic [3:0] tick_reg;
   logic [3:0] bit_reg;
   logic [3:0] nbits;
   logic [3:0] last_tick;
   logic [3:0] half_tick;

   assign nbits = char_bits(char_size_field);
   assign last_tick = double_speed ? 4'h7 : 4'hF;
   assign half_tick = double_speed ? 4'h3 : 4'h7;

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= RX_IDLE;
         tick_reg <= 4'h0;
         bit_reg <= 4'h0;
         data_out <= 9'h000;
         done <= 1'b0;
         frame_err <= 1'b0;
         parity_err <= 1'b0;
      end else begin
         done <= 1'b0;
         unique case (state_reg)
            RX_IDLE: begin
               if (enable && !rxd) begin
                  state_reg <= RX_START;
                  tick_reg <= 4'h0;
               end
            end
            RX_START: begin
               if (baud_tick) begin
                  tick_reg <= tick_reg + 4'h1;
                  if (tick_reg == half_tick) begin
                     tick_reg <= 4'h0;
                     bit_reg <= 4'h0;
                     data_out <= 9'h000;
                     state_reg <= rxd ? RX_IDLE : RX_DATA;
                  end
               end
            end
            default: begin
               if (baud_tick) begin
                  tick_reg <= tick_reg + 4'h1;
                  if (tick_reg == last_tick) begin
                     tick_reg <= 4'h0;
                     if (state_reg == RX_DATA) begin
                        data_out[bit_reg] <= rxd;
                        bit_reg <= bit_reg + 4'h1;
                        if (bit_reg == nbits - 4'h1) begin
                           state_reg <= parity_mode_field[1] ?
                                        RX_PARITY : RX_STOP;
                        end
                     end else if (state_reg == RX_PARITY) begin
                        parity_err <= rxd ^ parity_of(data_out, nbits,
                                      parity_mode_field[0]);
                        state_reg <= RX_STOP;
                     end else begin
                        // only the first stop bit is looked at
                        frame_err <= ~rxd;
                        if (!parity_mode_field[1]) begin
                           parity_err <= 1'b0;
                        end
                        done <= 1'b1;
                        state_reg <= RX_IDLE;
                     end
                  end
               end
            end
         endcase
      end
   end

endmodule

// [uart_frame_tx.sv]
// Purpose: serial port with frame formatting transmit path
// Assumes: register port strobes are one cycle, read data next cycle
// Notes: control C shares its index with the high baud divisor
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

module uart_frame_tx
   import uart_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // serial pins
   output logic txd_out,
   output logic txd_oe,
   input wire logic rxd_in,
   input wire logic xck_in,
   output logic xck_out,
   output logic xck_oe
);
   import uart_pkg::*;

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   logic [2:0] char_size_field;
   logic [1:0] parity_mode_field;
   logic stop_bits_select;
   logic sync_mode_reg;
   logic polarity_reg;
   logic double_speed_bit;
   logic transmitter_enable;
   logic receiver_enable;
   logic sync_master_reg;
   logic tx_ninth_bit;
   logic [11:0] baud_div_reg;

   logic wr_data;
   logic wr_a;
   logic wr_b;
   logic wr_c;
   logic wr_low;
   logic rd_data;

   assign wr_data = wr && addr == ADDR_DATA;
   assign wr_a = wr && addr == ADDR_CTRL_A;
   assign wr_b = wr && addr == ADDR_CTRL_B;
   assign wr_c = wr && addr == ADDR_CTRL_C;
   assign wr_low = wr && addr == ADDR_BAUD_LOW;
   assign rd_data = rd && addr == ADDR_DATA;

   always_ff @(posedge clk) begin
      if (rst) begin
         char_size_field <= CHAR_SIZE_RESET;
         parity_mode_field <= PARITY_RESET;
         stop_bits_select <= 1'b0;
         sync_mode_reg <= 1'b0;
         polarity_reg <= 1'b0;
         double_speed_bit <= 1'b0;
         transmitter_enable <= 1'b0;
         receiver_enable <= 1'b0;
         sync_master_reg <= 1'b0;
         tx_ninth_bit <= 1'b0;
         baud_div_reg <= BAUD_RESET;
      end else begin
         if (wr_a) begin
            double_speed_bit <= wdata[A_DOUBLE];
         end
         if (wr_b) begin
            sync_master_reg <= wdata[B_SYNC_MASTER];
            receiver_enable <= wdata[B_RX_EN];
            transmitter_enable <= wdata[B_TX_EN];
            char_size_field[2] <= wdata[B_SIZE2];
            tx_ninth_bit <= wdata[B_TX_NINTH];
         end
         // select bit picks control C over the high divisor
         if (wr_c && wdata[C_SELECT]) begin
            sync_mode_reg <= wdata[C_SYNC];
            parity_mode_field <= wdata[C_PARITY_HI:C_PARITY_LO];
            stop_bits_select <= wdata[C_STOP2];
            char_size_field[1:0] <= wdata[C_SIZE_HI:C_SIZE_LO];
            polarity_reg <= wdata[C_POLARITY];
         end else if (wr_c) begin
            baud_div_reg[11:8] <= wdata[3:0];
         end
         if (wr_low) begin
            baud_div_reg[7:0] <= wdata;
         end
      end
   end

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic rxd_s1;
   logic rxd_s2;
   logic xck_s1;
   logic xck_s2;
   logic xck_s3;

   always_ff @(posedge clk) begin
      if (rst) begin
         rxd_s1 <= 1'b1;
         rxd_s2 <= 1'b1;
         xck_s1 <= 1'b0;
         xck_s2 <= 1'b0;
         xck_s3 <= 1'b0;
      end else begin
         rxd_s1 <= rxd_in;
         rxd_s2 <= rxd_s1;
         xck_s1 <= xck_in;
         xck_s2 <= xck_s1;
         xck_s3 <= xck_s2;
      end
   end

   // ------------------------------------------------------------
   // baud generator and bit pacing
   // ------------------------------------------------------------
   logic [11:0] baud_cnt_reg;
   logic baud_tick;
   logic [4:0] presc_reg;
   logic [4:0] tx_div;
   logic bit_tick;
   logic slave_mode;
   logic change_edge;
   logic load;

   assign baud_tick = baud_cnt_reg == 12'h000;
   assign slave_mode = sync_mode_reg && !sync_master_reg;
   assign tx_div = sync_mode_reg ? DIV_SYNC :
                   double_speed_bit ? DIV_DOUBLE : DIV_NORMAL;
   // data changes on the rising edge unless polarity is set
   assign change_edge = polarity_reg ? (xck_s3 && !xck_s2) :
                        (!xck_s3 && xck_s2);

   always_comb begin
      if (slave_mode) begin
         bit_tick = change_edge;
      end else if (sync_mode_reg) begin
         bit_tick = baud_tick && (xck_out == polarity_reg);
      end else begin
         bit_tick = baud_tick && presc_reg == tx_div - 5'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         baud_cnt_reg <= BAUD_RESET;
      end else if (wr_low) begin
         baud_cnt_reg <= {baud_div_reg[11:8], wdata};
      end else if (baud_tick) begin
         baud_cnt_reg <= baud_div_reg;
      end else begin
         baud_cnt_reg <= baud_cnt_reg - 12'h001;
      end
   end

   // restarting the prescaler on load gives a full-length start bit
   always_ff @(posedge clk) begin
      if (rst) begin
         presc_reg <= 5'h00;
      end else if (load || bit_tick) begin
         presc_reg <= 5'h00;
      end else if (baud_tick) begin
         presc_reg <= presc_reg + 5'h01;
      end
   end

   // master clock output toggles once per baud tick
   always_ff @(posedge clk) begin
      if (rst) begin
         xck_out <= 1'b0;
         xck_oe <= 1'b0;
      end else begin
         xck_oe <= sync_mode_reg && sync_master_reg;
         if (!(sync_mode_reg && sync_master_reg)) begin
            xck_out <= polarity_reg;
         end else if (baud_tick) begin
            xck_out <= ~xck_out;
         end
      end
   end

   // ------------------------------------------------------------
   // transmit buffer
   // ------------------------------------------------------------
   logic [8:0] buf_reg;
   logic buf_full_reg;
   logic [3:0] nbits;
   logic [8:0] size_mask;

   assign nbits = char_bits(char_size_field);
   assign size_mask = 9'h1FF >> (4'h9 - nbits);

   always_ff @(posedge clk) begin
      if (rst) begin
         buf_reg <= 9'h000;
      end else if (wr_data) begin
         buf_reg <= {tx_ninth_bit, wdata} & size_mask;
      end
   end

   // a write in the load cycle refills the buffer, so the write wins
   always_ff @(posedge clk) begin
      if (rst) begin
         buf_full_reg <= 1'b0;
      end else if (wr_data) begin
         buf_full_reg <= 1'b1;
      end else if (load) begin
         buf_full_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // shift register and frame sequencer
   // ------------------------------------------------------------
   tx_state_t state_reg;
   logic [8:0] shift_reg;
   logic [3:0] bit_cnt_reg;
   logic parity_reg;
   logic frame_end;

   assign frame_end = bit_tick && ((state_reg == TX_STOP1 &&
                      !stop_bits_select) || state_reg == TX_STOP2);
   assign load = buf_full_reg && transmitter_enable &&
                 (state_reg == TX_IDLE || frame_end);

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= TX_IDLE;
         shift_reg <= 9'h000;
         bit_cnt_reg <= 4'h0;
         parity_reg <= 1'b0;
         txd_out <= 1'b1;
      end else if (load) begin
         shift_reg <= buf_reg;
         parity_reg <= parity_of(buf_reg, nbits,
                                 parity_mode_field[0]);
         state_reg <= TX_START;
         txd_out <= 1'b0;
      end else if (bit_tick) begin
         unique case (state_reg)
            TX_IDLE: begin
               txd_out <= 1'b1;
            end
            TX_START: begin
               txd_out <= shift_reg[0];
               bit_cnt_reg <= 4'h0;
               state_reg <= TX_DATA;
            end
            TX_DATA: begin
               shift_reg <= shift_reg >> 1;
               bit_cnt_reg <= bit_cnt_reg + 4'h1;
               if (bit_cnt_reg != nbits - 4'h1) begin
                  txd_out <= shift_reg[1];
               end else if (parity_mode_field[1]) begin
                  txd_out <= parity_reg;
                  state_reg <= TX_PARITY;
               end else begin
                  txd_out <= 1'b1;
                  state_reg <= TX_STOP1;
               end
            end
            TX_PARITY: begin
               txd_out <= 1'b1;
               state_reg <= TX_STOP1;
            end
            TX_STOP1: begin
               txd_out <= 1'b1;
               state_reg <= stop_bits_select ? TX_STOP2 : TX_IDLE;
            end
            TX_STOP2: begin
               txd_out <= 1'b1;
               state_reg <= TX_IDLE;
            end
            default: begin
               txd_out <= 1'b1;
               state_reg <= TX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         txd_oe <= 1'b0;
      end else begin
         txd_oe <= transmitter_enable;
      end
   end

   // ------------------------------------------------------------
   // receiver and status flags
   // ------------------------------------------------------------
   logic [8:0] rx_data;
   logic rx_done;
   logic rx_frame_err;
   logic rx_parity_err;
   logic [8:0] rx_hold_reg;
   logic frame_error_flag;
   logic parity_error_flag;
   logic rx_complete_flag;
   logic tx_complete_flag;

   uart_frame_receiver u_rx (
      .clk(clk),
      .rst(rst),
      .rxd(rxd_s2),
      .baud_tick(baud_tick),
      .enable(receiver_enable && !sync_mode_reg),
      .double_speed(double_speed_bit),
      .char_size_field(char_size_field),
      .parity_mode_field(parity_mode_field),
      .data_out(rx_data),
      .done(rx_done),
      .frame_err(rx_frame_err),
      .parity_err(rx_parity_err)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         rx_hold_reg <= 9'h000;
         frame_error_flag <= 1'b0;
         parity_error_flag <= 1'b0;
      end else if (rx_done) begin
         rx_hold_reg <= rx_data;
         frame_error_flag <= rx_frame_err;
         parity_error_flag <= rx_parity_err;
      end
   end

   // new character wins over a read in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_complete_flag <= 1'b0;
      end else if (rx_done) begin
         rx_complete_flag <= 1'b1;
      end else if (rd_data) begin
         rx_complete_flag <= 1'b0;
      end
   end

   // set wins over a write-one clear in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_complete_flag <= 1'b0;
      end else if (frame_end && !buf_full_reg) begin
         tx_complete_flag <= 1'b1;
      end else if (wr_a && wdata[A_TXC]) begin
         tx_complete_flag <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // register read
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= 8'h00;
      end else if (rd) begin
         rdata <= 8'h00;
         unique case (addr)
            ADDR_DATA: begin
               rdata <= rx_hold_reg[7:0];
            end
            ADDR_CTRL_A: begin
               rdata[A_RXC] <= rx_complete_flag;
               rdata[A_TXC] <= tx_complete_flag;
               rdata[A_BUF_EMPTY] <= !buf_full_reg;
               rdata[A_FRAME_ERR] <= frame_error_flag;
               rdata[A_PARITY_ERR] <= parity_error_flag;
               rdata[A_DOUBLE] <= double_speed_bit;
            end
            ADDR_CTRL_B: begin
               rdata[B_SYNC_MASTER] <= sync_master_reg;
               rdata[B_RX_EN] <= receiver_enable;
               rdata[B_TX_EN] <= transmitter_enable;
               rdata[B_SIZE2] <= char_size_field[2];
               rdata[B_RX_NINTH] <= rx_hold_reg[8];
               rdata[B_TX_NINTH] <= tx_ninth_bit;
            end
            ADDR_CTRL_C: begin
               rdata <= {1'b1, sync_mode_reg, parity_mode_field,
                         stop_bits_select, char_size_field[1:0],
                         polarity_reg};
            end
            ADDR_BAUD_LOW: begin
               rdata <= baud_div_reg[7:0];
            end
            default: begin
               rdata <= 8'h00;
            end
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

endmodule

// [uart_frame_tx_bench.sv]
// Purpose: self-checking bench of the frame transmitter
// Assumes: divisor 0, 16 or 8 clock cycles per bit
// Notes: two back-to-back characters in every frame format
`timescale 1ns/1ps
module uart_frame_tx_bench;
   import uart_pkg::*;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
   logic [2:0] addr = 3'h0, sz = 3'h3;
   logic [7:0] wdata = 8'h00, rdata, v;
   logic txd_out, txd_oe, xck_out, xck_oe, rxd, frame_vld;
   logic [10:0] frame;
   logic [10:0] expq[$];
   logic [3:0] nbits = 4'h8;
   logic par_en = 1'b0, stop2 = 1'b0, dbl = 1'b0;
   logic [4:0] per = 5'h10;
   logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
   int miscompares = 0, comparisons = 0, cyc = 0;
   integer seed = 32'h85222fef;
   always #50 clk = ~clk;
   uart_frame_tx dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .txd_out(txd_out), .txd_oe(txd_oe),
      .rxd_in(rxd), .xck_in(1'b0), .xck_out(xck_out), .xck_oe(xck_oe));
   serial_peer peer (.clk(clk), .txd(txd_out), .nbits(nbits),
      .par_en(par_en), .stop2(stop2), .per(per), .rxd(rxd), .frame(frame),
      .frame_vld(frame_vld));
   task automatic test_done();
      if (miscompares == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      chk({3'h0, got}, {3'h0, exp});
   endtask
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] x);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= x;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [2:0] a);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      v = rdata;
   endtask
   task automatic send(input logic [8:0] x, input logic odd);
      logic [8:0] m;
      m = x & ~(9'h1FF << nbits);
      expq.push_back({1'b1, par_en & (^m ^ odd), m});
      do rd_reg(ADDR_CTRL_A); while (v[A_BUF_EMPTY] !== 1'b1);
      wr_reg(ADDR_CTRL_B, {4'h1, 1'b1, sz[2], 1'b0, x[8]});
      wr_reg(ADDR_DATA, x[7:0]);
   endtask
   task automatic wait_done();
      for (int i = 0; i < 500; i++) begin
         rd_reg(ADDR_CTRL_A);
         if (v[A_TXC] === 1'b1) break;
      end
      chk_reg(v, {6'h18, dbl, 1'b0});
      wr_reg(ADDR_CTRL_A, {6'h10, dbl, 1'b0});
      rd_reg(ADDR_CTRL_A);
      chk_reg(v, {6'h08, dbl, 1'b0});
   endtask
   // oldest expected frame is compared when the peer reports one
   always @(posedge frame_vld) begin
      chk(frame, expq.size() ? expq.pop_front() : 11'bx);
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         miscompares++;
         test_done();
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rd_reg(ADDR_CTRL_A);
      chk_reg(v, 8'h20);
      rd_reg(ADDR_CTRL_C);
      chk_reg(v, 8'h86);
      rd_reg(3'h7);
      chk_reg(v, 8'h00);
      // all thirty formats
      for (int s = 0; s < 5; s++) begin
         for (int p = 0; p < 3; p++) begin
            for (int t = 0; t < 2; t++) begin
               sz = codes[s];
               nbits = 4'(s + 5);
               par_en = (p != 0);
               stop2 = t[0];
               dbl = s[0] ^ p[0] ^ t[0];
               per = dbl ? 5'h08 : 5'h10;
               wr_reg(ADDR_CTRL_A, {6'h00, dbl, 1'b0});
               wr_reg(ADDR_CTRL_C,
                  {2'h2, par_en, p == 2, stop2, sz[1:0], dbl});
               send(9'($random(seed)), p == 2);
               send(9'($random(seed)), p == 2);
               rd_reg(ADDR_CTRL_A);
               chk_reg(v, {6'h00, dbl, 1'b0});
               wait_done();
            end
         end
      end
      wr_reg(ADDR_CTRL_B, 8'h00);
      repeat (4) @(posedge clk);
      chk(11'(expq.size()), 11'h000);
      test_done();
   end
endmodule

bind uart_frame_tx uart_frame_tx_chk chk (.clk(clk), .rst(rst), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .txd_out(txd_out),
   .txd_oe(txd_oe), .xck_out(xck_out), .xck_oe(xck_oe));

// [uart_frame_tx_chk.sv]
// Purpose: port assertions of the frame transmitter
// Assumes: divisor 0, no sync mode, double speed mirrored from writes
// Notes: bound from the bench top file
`timescale 1ns/1ps
module uart_frame_tx_chk
   import uart_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   // serial pins
   input wire logic txd_out,
   input wire logic txd_oe,
   input wire logic xck_out,
   input wire logic xck_oe
);
   logic last_reg;
   logic dbl_reg;
   logic pol_reg;
   logic [7:0] run_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // length of the current level on the line
   always_ff @(posedge clk) begin
      last_reg <= txd_out;
      if (rst) begin
         run_reg <= 8'h00;
      end else begin
         run_reg <= (txd_out != last_reg) ? 8'h01 : run_reg + 8'h01;
      end
   end
   // mirrors of the double speed and clock polarity settings
   always_ff @(posedge clk) begin
      if (rst) begin
         dbl_reg <= 1'b0;
         pol_reg <= 1'b0;
      end else begin
         if (wr && addr == ADDR_CTRL_A) begin
            dbl_reg <= wdata[A_DOUBLE];
         end
         if (wr && addr == ADDR_CTRL_C && wdata[C_SELECT]) begin
            pol_reg <= wdata[C_POLARITY];
         end
      end
   end
   reset_state_a: assert property (
      $fell(rst) |-> txd_out && !txd_oe && !xck_oe && rdata == 8'h00)
      else $error("outputs wrong after reset");
   reset_idle_a: assert property ($fell(rst) |-> txd_out[*4])
      else $error("line not idle after reset");
   bit_hold_a: assert property (
      $changed(txd_out) |=> $stable(txd_out)[*7])
      else $error("bit shorter than its period");
   low_run_a: assert property (
      txd_out && !last_reg |->
      (run_reg[3:0] & (dbl_reg ? 4'h7 : 4'hF)) == 4'h0)
      else $error("low level not a whole number of bits");
   xck_idle_a: assert property (
      !xck_oe |-> xck_out == $past(pol_reg))
      else $error("clock pin output not at idle level");
   start_enabled_a: assert property ($fell(txd_out) |-> txd_oe)
      else $error("frame started while pin not driven");
   oe_follow_a: assert property (
      wr && addr == ADDR_CTRL_B |-> ##2 txd_oe == $past(wdata[B_TX_EN], 2))
      else $error("pin drive does not follow enable");
   rdata_quiet_a: assert property (!rd |=> rdata == 8'h00)
      else $error("read data without read");
   unmapped_rd_a: assert property (
      rd && addr > ADDR_BAUD_LOW |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   cover property ($fell(txd_out));
   cover property (wr && addr == ADDR_DATA);
   cover property (rd && addr == ADDR_CTRL_A);
endmodule

// [uart_pkg.sv]
// Purpose: shared constants, types and helpers of the serial port
// Assumes: 8-bit register port with a 3-bit register index
// Notes: frame settings are shared by transmitter and receiver
package uart_pkg;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam int ADDR_W = 3;
   localparam logic [2:0] ADDR_DATA = 3'h0;
   localparam logic [2:0] ADDR_CTRL_A = 3'h1;
   localparam logic [2:0] ADDR_CTRL_B = 3'h2;
   localparam logic [2:0] ADDR_CTRL_C = 3'h3;
   localparam logic [2:0] ADDR_BAUD_LOW = 3'h4;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int A_RXC = 7;
   localparam int A_TXC = 6;
   localparam int A_BUF_EMPTY = 5;
   localparam int A_FRAME_ERR = 4;
   localparam int A_PARITY_ERR = 2;
   localparam int A_DOUBLE = 1;
   localparam int B_SYNC_MASTER = 5;
   localparam int B_RX_EN = 4;
   localparam int B_TX_EN = 3;
   localparam int B_SIZE2 = 2;
   localparam int B_RX_NINTH = 1;
   localparam int B_TX_NINTH = 0;
   localparam int C_SELECT = 7;
   localparam int C_SYNC = 6;
   localparam int C_PARITY_HI = 5;
   localparam int C_PARITY_LO = 4;
   localparam int C_STOP2 = 3;
   localparam int C_SIZE_HI = 2;
   localparam int C_SIZE_LO = 1;
   localparam int C_POLARITY = 0;

   // ------------------------------------------------------------
   // reset values and encodings
   // ------------------------------------------------------------
   localparam logic [2:0] CHAR_SIZE_RESET = 3'h3;
   localparam logic [1:0] PARITY_RESET = 2'h0;
   localparam logic [11:0] BAUD_RESET = 12'h000;
   localparam logic [1:0] PARITY_EVEN = 2'h2;
   localparam logic [1:0] PARITY_ODD = 2'h3;

   // transmitter divides the baud generator output by these
   localparam logic [4:0] DIV_NORMAL = 5'h10;
   localparam logic [4:0] DIV_DOUBLE = 5'h08;
   localparam logic [4:0] DIV_SYNC = 5'h02;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_START = 3'b001,
      TX_DATA = 3'b010,
      TX_PARITY = 3'b011,
      TX_STOP1 = 3'b100,
      TX_STOP2 = 3'b101
   } tx_state_t;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b000,
      RX_START = 3'b001,
      RX_DATA = 3'b010,
      RX_PARITY = 3'b011,
      RX_STOP = 3'b100
   } rx_state_t;

   // number of data bits for a character size code
   function automatic logic [3:0] char_bits(input logic [2:0] size);
      case (size)
         3'h0: return 4'h5;
         3'h1: return 4'h6;
         3'h2: return 4'h7;
         3'h7: return 4'h9;
         default: return 4'h8;
      endcase
   endfunction

   // xor of the first nbits data bits, inverted for odd parity
   function automatic logic parity_of(input logic [8:0] d,
                                      input logic [3:0] nbits,
                                      input logic odd);
      logic p;
      p = odd;
      for (int i = 0; i < 9; i++) begin
         if (4'(i) < nbits) begin
            p = p ^ d[i];
         end
      end
      return p;
   endfunction

endpackage
